// File: design/irq_agg_defs.svh
`ifndef IRQ_AGG_DEFS_SVH
`define IRQ_AGG_DEFS_SVH

// Register offsets
`define IRQ_CONTROL_OFFSET 8'h23
`define IRQ_STATUS_OFFSET 8'h24

// Field positions shared by the control and status registers
`define IRQ_GLOBAL_BIT 7
`define IRQ_TX_BIT 4
`define IRQ_RX_MSB 3
`define IRQ_RX_LSB 0

// Reset values
`define IRQ_CONTROL_RESET 8'h00
`define IRQ_PENDING_RESET 5'h00

// Writable mask of the control register (bits 7, 5, 4, 3:0)
`define IRQ_CONTROL_WMASK 8'hbf

`endif

// File: design/irq_agg_pkg.sv
package irq_agg_pkg;

   // Event inputs from the sources
   typedef struct packed {
      logic tx_event;
      logic [3:0] rx_event;
   } src_event_s;

   // Read-to-clear strobes from the sources' own status registers
   typedef struct packed {
      logic tx_status_read;
      logic [3:0] rx_status_read;
   } src_clear_s;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// File: design/hub_interrupt_aggregator.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "irq_agg_defs.svh"

module hub_interrupt_aggregator (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire irq_agg_pkg::reg_req_s req_in,
   input wire irq_agg_pkg::src_event_s event_in,
   input wire irq_agg_pkg::src_clear_s clear_in,
   output logic [7:0] rdata_out,
   output logic irq_out
);

   // Address match shared by the write and the read decoders
   function automatic logic reg_hit(input logic [7:0] addr,
      input logic [7:0] offset);
      reg_hit = (addr == offset);
   endfunction

   // One pending bit: a set beats a clear, so no event is lost to a race
   function automatic logic pending_merge(input logic held,
      input logic set_ev, input logic clr);
      pending_merge = set_ev | (held & ~clr);
   endfunction

   // Stored control register; reserved bit 6 is never stored
   logic [7:0] control_q;
   logic [7:0] control_d;

   // Held pending bits: bit 4 transmit, bits 3..0 receive ports
   logic [4:0] pending_q;
   logic [4:0] pending_d;

   // Per-source enables and the global gate of the pin
   logic [4:0] enables;
   logic global_enable;

   // Summary as it stands now and with the pending bits it will hold after this edge
   logic summary;
   logic summary_d;

   // Register selects, already qualified by their strobes
   logic control_wr;
   logic control_rd;
   logic status_rd;

   // Read path words
   logic [7:0] status_word;
   logic [7:0] read_word;
   logic [7:0] rdata_d;

   // Pin value ahead of its flip-flop
   logic irq_d;

   // Register selects; the status register takes no writes at all
   assign control_wr = req_in.wr
      && reg_hit(req_in.addr, `IRQ_CONTROL_OFFSET);
   assign control_rd = req_in.rd
      && reg_hit(req_in.addr, `IRQ_CONTROL_OFFSET);
   assign status_rd = req_in.rd
      && reg_hit(req_in.addr, `IRQ_STATUS_OFFSET);

   // Next control value; the mask keeps reserved bit 6 at zero
   // while reserved bit 5 is kept and read back as plain storage
   always_comb begin
      control_d = control_q;
      if (control_wr) begin
         control_d = req_in.wdata & `IRQ_CONTROL_WMASK;
      end
   end

   // Control register
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         control_q <= `IRQ_CONTROL_RESET;
      end else begin
         control_q <= control_d;
      end
   end

   // Per-source enables: bit 4 transmit, bits 3..0 receive ports
   assign enables = {control_q[`IRQ_TX_BIT],
      control_q[`IRQ_RX_MSB:`IRQ_RX_LSB]};

   // Global gate; it only masks the pin, never the summary
   assign global_enable = control_q[`IRQ_GLOBAL_BIT];

   // Next pending bits from events and read-to-clear strobes.
   // A clear strobe comes from a read of the source's own status
   // register; if the source raises a fresh event in that very cycle
   // the bit must stay set, or the host would miss the new cause.
   always_comb begin
      pending_d = pending_q;
      pending_d[`IRQ_TX_BIT] = pending_merge(pending_q[`IRQ_TX_BIT],
         event_in.tx_event, clear_in.tx_status_read);
      for (int i = `IRQ_RX_LSB; i <= `IRQ_RX_MSB; i++) begin
         pending_d[i] = pending_merge(pending_q[i],
            event_in.rx_event[i], clear_in.rx_status_read[i]);
      end
   end

   // Pending register
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         pending_q <= `IRQ_PENDING_RESET;
      end else begin
         pending_q <= pending_d;
      end
   end

   // Summary of the held pending bits, blind to the global enable
   assign summary = |(pending_q & enables);

   // Summary looked ahead one cycle so the pin moves with status bit 7
   // after an event or a clear; a control write reaches the pin one
   // cycle after it reaches the status bit
   assign summary_d = |(pending_d & enables);

   // Status word: summary, two reserved zeros, the five pending bits
   assign status_word = {summary, 2'h0, pending_q};

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      read_word = 8'h00;
      if (control_rd) begin
         read_word = control_q;
      end else if (status_rd) begin
         read_word = status_word;
      end
   end

   // Read data stands only in the cycle after the strobe, else zero,
   // so a host that samples late sees zero rather than stale data
   assign rdata_d = req_in.rd ? read_word : 8'h00;

   // Read data register
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rdata_d;
      end
   end

   // Pin value: global enable AND the summary to come
   assign irq_d = summary_d & global_enable;

   // Interrupt pin, straight from a flip-flop to avoid glitches
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= irq_d;
      end
   end

   // Limitation: the source status registers live outside this block;
   // their reads arrive here only as one-cycle clear strobes, and a
   // strobe that is held high clears the bit again every cycle, so an event stays set for one cycle only.

endmodule

// File: testbench/irq_agg_monitor.sv
`timescale 1ns/1ps
module irq_agg_monitor(input wire logic mclk_in, reset_in, irq_out,
   input wire logic [7:0] rdata_out, input wire irq_agg_pkg::reg_req_s req_in,
   input wire irq_agg_pkg::src_event_s event_in,
   input wire irq_agg_pkg::src_clear_s clear_in);
   logic [7:0] c_q;
   logic wc;
   // Control shadow; bit 6 is masked at compare
   assign wc = req_in.wr && req_in.addr == 8'h23;
   always_ff @(posedge mclk_in)
      c_q <= reset_in ? 8'h00 : wc ? req_in.wdata : c_q;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   a_irq_gate: assert property (irq_out |-> c_q[7] | $past(c_q[7]))
      else $error("irq without global enable");
   a_reset_zero: assert property ($fell(reset_in) |-> !irq_out)
      else $error("irq after reset");
   a_ctl_read: assert property ($past(req_in.rd && req_in.addr == 8'h23) |->
      rdata_out == ($past(c_q) & 8'hbf)) else $error("control readback");
   a_sum_bit: assert property ($past(req_in.rd && req_in.addr == 8'h24) |->
      rdata_out[7] == |(rdata_out[4:0] & $past(c_q[4:0]))) else $error("summary");
   a_event_irq: assert property (c_q[7] && |(event_in & c_q[4:0]) |=> irq_out)
      else $error("event lost");
   a_no_src: assert property (c_q[4:0] == 5'h00 && $past(c_q[4:0]) == 5'h00 |->
      !irq_out) else $error("irq from disabled");
   a_clear_all: assert property (clear_in == 5'h1f && event_in == 5'h00
      |=> !irq_out)
      else $error("clear ignored");
   a_unmapped: assert property ($past(req_in.rd && req_in.addr > 8'h24) |->
      rdata_out == 8'h00) else $error("unmapped read");
   c_irq: cover property (irq_out);
   c_race: cover property (event_in != 5'h00 && clear_in != 5'h00);
   c_quiet: cover property (rdata_out[7] && !c_q[7]);
endmodule
bind hub_interrupt_aggregator irq_agg_monitor mon(.mclk_in, .reset_in,
   .irq_out, .rdata_out, .req_in, .event_in, .clear_in);

// File: testbench/irq_host.sv
`timescale 1ns/1ps
// Host end counts interrupt assertions
module irq_host(input wire logic mclk_in, irq_in, output int seen_out);
   logic p_q = 1'b0;
   always_ff @(posedge mclk_in)
      {p_q, seen_out} <= {irq_in, seen_out + (irq_in & !p_q)};
endmodule

// File: testbench/hub_interrupt_aggregator_tb.sv
`timescale 1ns/1ps
module hub_interrupt_aggregator_tb;
   logic mclk_in = 0, reset_in = 1, irq;
   irq_agg_pkg::reg_req_s q = '0;
   irq_agg_pkg::src_event_s ev = '0;
   irq_agg_pkg::src_clear_s cl = '0;
   logic [7:0] rd_d;
   int n_mismatch = 0, cmp_count = 0, seen;
   hub_interrupt_aggregator DUT(.mclk_in, .reset_in, .req_in(q),
      .event_in(ev), .clear_in(cl), .rdata_out(rd_d), .irq_out(irq));
   irq_host host(.mclk_in, .irq_in(irq), .seen_out(seen));
   initial forever #2 mclk_in = ~mclk_in;
   task chk(string n, logic [7:0] e, s);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   // Strobe then one idle edge, so no signal is assigned twice at once
   task acc(logic [17:0] v);
      q <= v;
      @(posedge mclk_in) q <= '0;
      @(posedge mclk_in);
   endtask
   // Read data stands only in the cycle after the strobe: look mid-cycle
   task rd(string n, logic [7:0] a, e);
      q <= {a, 8'h00, 2'b01};
      @(posedge mclk_in) q <= '0;
      @(negedge mclk_in) chk(n, e, rd_d);
      @(posedge mclk_in);
   endtask
   task ev_p(logic [4:0] e, c);
      {ev, cl} <= {e, c};
      @(posedge mclk_in) {ev, cl} <= '0;
      @(posedge mclk_in);
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk_in);
      reset_in <= 0;
      rd("status", 8'h24, 8'h00);
      acc({8'h23, 8'h6f, 2'b10});
      acc({8'h24, 8'hff, 2'b10});
      rd("control", 8'h23, 8'h2f);
      rd("unmapped", 8'h25, 8'h00);
      ev_p(5'h10, 5'h00);
      rd("status", 8'h24, 8'h10);
      ev_p(5'h01, 5'h01);
      rd("status", 8'h24, 8'h91);
      chk("irq", 8'h00, {7'h00, irq});
      acc({8'h23, 8'h81, 2'b10});
      rd("status", 8'h24, 8'h91);
      chk("irq", 8'h01, {7'h00, irq});
      ev_p(5'h00, 5'h11);
      rd("status", 8'h24, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      chk("host", 8'h01, seen[7:0]);
      $display("test enables done");
      acc({8'h23, 8'h90, 2'b10});
      ev_p(5'h10, 5'h00);
      rd("status", 8'h24, 8'h90);
      chk("irq", 8'h01, {7'h00, irq});
      chk("host", 8'h02, seen[7:0]);
      $display("test transmit done");
      reset_in <= 1;
      repeat (2) @(posedge mclk_in);
      reset_in <= 0;
      rd("control", 8'h23, 8'h00);
      rd("status", 8'h24, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      $display("test reset done");
      test_done();
   end
   initial begin
      #2000 n_mismatch++;
      test_done();
   end
endmodule
